// ---- design/nic_pkg.sv ----
// nic_pkg: constants and types of the nested priority interrupt controller
// assumes: one 20 MHz clock, AXI4-Lite register access, 8-bit core beside it
package nic_pkg;
    // vectors and source groups
    localparam int NVEC = 14;
    localparam int NGRP = 4;
    localparam int EXT_VEC0 = 2;
    localparam logic [13:0] PERIPH_VECS = 14'h3FC2;
    // register byte offsets
    localparam logic [7:0] OFS_PRIO0 = 8'h00;
    localparam logic [7:0] OFS_PRIO1 = 8'h04;
    localparam logic [7:0] OFS_PRIO2 = 8'h08;
    localparam logic [7:0] OFS_PRIO3 = 8'h0C;
    localparam logic [7:0] OFS_SENS = 8'h10;
    localparam logic [7:0] OFS_PINEN = 8'h14;
    localparam logic [7:0] OFS_PEN = 8'h18;
    localparam logic [7:0] OFS_STAT = 8'h1C;
    localparam logic [7:0] OFS_PCLR = 8'h20;
    // reset values
    localparam logic [31:0] PRIO_RST = 32'hFFFFFFFF;
    localparam logic [31:0] PRIO_RO_ONES = 32'hF0000000;
    localparam logic [9:0] SENS_RST = 10'h000;
    // software level codes, {high,low}
    localparam logic [1:0] LVL0 = 2'b10;
    localparam logic [1:0] LVL1 = 2'b01;
    localparam logic [1:0] LVL2 = 2'b00;
    localparam logic [1:0] LVL3 = 2'b11;
    localparam int CC_HI_BIT = 5;
    localparam int CC_LO_BIT = 3;
    // vector addresses, top of map
    localparam logic [15:0] VEC_RESET = 16'hFFFE;
    localparam logic [15:0] VEC_TRAP = 16'hFFFC;
    localparam logic [15:0] VEC_TOP = 16'hFFFA;
    // external sensitivity per group
    localparam logic [1:0] SENS_RISE = 2'b00;
    localparam logic [1:0] SENS_FALL = 2'b01;
    localparam logic [1:0] SENS_BOTH = 2'b10;
    localparam logic [1:0] SENS_LOW = 2'b11;
    localparam int TLI_EDGE_BIT = 8;
    localparam int TLI_EN_BIT = 9;
    // bus responses
    localparam logic [1:0] RESP_OKAY = 2'b00;
    localparam logic [1:0] RESP_SLVERR = 2'b10;
    typedef enum logic [1:0] {
        NIC_RUN = 2'b00,
        NIC_STACK = 2'b01,
        NIC_VECT = 2'b11,
        NIC_RSTV = 2'b10
    } nic_state_t;
endpackage

// ---- design/nic_top.sv ----
// nic_top: nested priority interrupt controller with AXI4-Lite registers
// assumes: core pulses instruction end, trap, stack done; inputs synchronous
//
// Local design decisions: the register addresses and register access over AXI4-Lite.
`timescale 1ns/1ps
module nic_top #(
    parameter int GRP_W = 4
) (
    input wire logic MCLK,
    input wire logic NRST,
    input wire logic [7:0] AWADDR,
    input wire logic AWVALID,
    output logic AWREADY,
    input wire logic [31:0] WDATA,
    input wire logic [3:0] WSTRB,
    input wire logic WVALID,
    output logic WREADY,
    output logic [1:0] BRESP,
    output logic BVALID,
    input wire logic BREADY,
    input wire logic [7:0] ARADDR,
    input wire logic ARVALID,
    output logic ARREADY,
    output logic [31:0] RDATA,
    output logic [1:0] RRESP,
    output logic RVALID,
    input wire logic RREADY,
    input wire logic TOP_LEVEL_PIN,
    input wire logic [nic_pkg::NGRP*GRP_W-1:0] EXT_PINS,
    input wire logic [13:0] PERIPH_FLAG,
    input wire logic CPU_INSTR_END,
    input wire logic CPU_TRAP,
    input wire logic CPU_STACK_DONE,
    input wire logic RETURN_FROM_IRQ,
    input wire logic CPU_CC_LOAD,
    input wire logic [7:0] CPU_CC_DATA,
    output logic CPU_STACK_REQ,
    output logic CPU_VEC_LOAD,
    output logic [15:0] PROGRAM_COUNTER_VEC,
    output logic [7:0] CONDITION_CODE_LVL,
    output logic WAKE_WAIT,
    output logic WAKE_STOP
);
    localparam int PW = nic_pkg::NGRP * GRP_W;

    // group width the pin enable word can carry
    if (GRP_W < 1 || GRP_W > 8) begin : g_bad_grp_w
        $error("nic_top: GRP_W must be 1 to 8");
    end

    // rank of a level code, 0 lowest
    function automatic logic [2:0] rank(input logic [1:0] c);
        case (c)
            nic_pkg::LVL0: rank = 3'd0;
            nic_pkg::LVL1: rank = 3'd1;
            nic_pkg::LVL2: rank = 3'd2;
            default: rank = 3'd3;
        endcase
    endfunction

    // register and bus state
    logic [31:0] prio_r, prio_nxt;
    logic [9:0] sens_r, sens_nxt;
    logic [PW-1:0] pinen_r, pinen_nxt;
    logic [13:0] pen_r, pen_nxt;
    logic aw_hold_r, aw_hold_nxt, w_hold_r, w_hold_nxt;
    logic [7:0] awaddr_r, awaddr_nxt;
    logic [31:0] wdata_r, wdata_nxt;
    logic [3:0] wstrb_r, wstrb_nxt;
    logic bvalid_r, bvalid_nxt, rvalid_r, rvalid_nxt;
    logic [1:0] bresp_r, bresp_nxt, rresp_r, rresp_nxt;
    logic [31:0] rdata_r, rdata_nxt;
    // source state
    logic [nic_pkg::NGRP-1:0] ext_prev_r, ext_prev_nxt, ext_lat_r, ext_lat_nxt;
    logic [13:0] per_prev_r, per_prev_nxt, per_lat_r, per_lat_nxt;
    logic tli_prev_r, tli_prev_nxt, tli_lat_r, tli_lat_nxt;
    logic trap_lat_r, trap_lat_nxt, in_tli_r, in_tli_nxt;
    // sequencing state
    nic_pkg::nic_state_t state_r, state_nxt;
    logic [3:0] sel_r, sel_nxt;
    logic sel_trap_r, sel_trap_nxt;
    logic [1:0] sel_lvl_r, sel_lvl_nxt, level_r, level_nxt;
    logic [15:0] vec_r, vec_nxt;
    // combinational helpers
    logic wr_go;
    logic [31:0] wmask, rd_val;
    logic wr_hit, rd_hit;
    logic [13:0] pclr, pend;
    logic [nic_pkg::NGRP-1:0] line, ext_req;
    logic found, take;
    logic [3:0] best_idx;
    logic [2:0] best_rank;

    assign wr_go = aw_hold_r && w_hold_r && !bvalid_r;
    assign wmask = {{8{wstrb_r[3]}}, {8{wstrb_r[2]}},
                    {8{wstrb_r[1]}}, {8{wstrb_r[0]}}};
    assign wr_hit = (awaddr_r[1:0] == 2'b00) && (awaddr_r <= nic_pkg::OFS_PCLR);
    assign rd_hit = (ARADDR[1:0] == 2'b00) && (ARADDR <= nic_pkg::OFS_PCLR);
    assign pclr = (wr_go && awaddr_r == nic_pkg::OFS_PCLR && wstrb_r[0])
                  ? wdata_r[13:0] : 14'h0000;

    // read mux
    always_comb begin
        case (ARADDR)
            nic_pkg::OFS_PRIO0: rd_val = {24'h000000, prio_r[7:0]};
            nic_pkg::OFS_PRIO1: rd_val = {24'h000000, prio_r[15:8]};
            nic_pkg::OFS_PRIO2: rd_val = {24'h000000, prio_r[23:16]};
            nic_pkg::OFS_PRIO3: rd_val = {24'h000000, prio_r[31:24]};
            nic_pkg::OFS_SENS: rd_val = {22'h000000, sens_r};
            nic_pkg::OFS_PINEN: rd_val = 32'(pinen_r);
            nic_pkg::OFS_PEN: rd_val = {18'h00000, pen_r};
            nic_pkg::OFS_STAT: rd_val = {12'h000, in_tli_r, trap_lat_r,
                                         state_r, level_r, pend};
            default: rd_val = 32'h00000000;
        endcase
    end

    // bus slave and software registers
    always_comb begin
        logic [31:0] p;
        p = prio_r;
        aw_hold_nxt = aw_hold_r;
        w_hold_nxt = w_hold_r;
        awaddr_nxt = awaddr_r;
        wdata_nxt = wdata_r;
        wstrb_nxt = wstrb_r;
        bvalid_nxt = bvalid_r && !BREADY;
        bresp_nxt = bresp_r;
        rvalid_nxt = rvalid_r && !RREADY;
        rresp_nxt = rresp_r;
        rdata_nxt = rdata_r;
        prio_nxt = prio_r;
        sens_nxt = sens_r;
        pinen_nxt = pinen_r;
        pen_nxt = pen_r;
        if (AWVALID && AWREADY) begin
            aw_hold_nxt = 1'b1;
            awaddr_nxt = AWADDR;
        end
        if (WVALID && WREADY) begin
            w_hold_nxt = 1'b1;
            wdata_nxt = WDATA;
            wstrb_nxt = WSTRB;
        end
        if (wr_go) begin
            aw_hold_nxt = 1'b0;
            w_hold_nxt = 1'b0;
            bvalid_nxt = 1'b1;
            bresp_nxt = wr_hit ? nic_pkg::RESP_OKAY : nic_pkg::RESP_SLVERR;
            case (awaddr_r)
                nic_pkg::OFS_PRIO0: p = {prio_r[31:8],
                    (prio_r[7:0] & ~wmask[7:0]) | (wdata_r[7:0] & wmask[7:0])};
                nic_pkg::OFS_PRIO1: p = {prio_r[31:16],
                    (prio_r[15:8] & ~wmask[7:0]) | (wdata_r[7:0] & wmask[7:0]),
                    prio_r[7:0]};
                nic_pkg::OFS_PRIO2: p = {prio_r[31:24],
                    (prio_r[23:16] & ~wmask[7:0]) | (wdata_r[7:0] & wmask[7:0]),
                    prio_r[15:0]};
                nic_pkg::OFS_PRIO3: p = {
                    (prio_r[31:24] & ~wmask[7:0]) | (wdata_r[7:0] & wmask[7:0]),
                    prio_r[23:0]};
                nic_pkg::OFS_SENS: sens_nxt = (sens_r & ~wmask[9:0])
                                              | (wdata_r[9:0] & wmask[9:0]);
                nic_pkg::OFS_PINEN: pinen_nxt = (pinen_r & ~wmask[PW-1:0])
                                                | (wdata_r[PW-1:0] & wmask[PW-1:0]);
                nic_pkg::OFS_PEN: pen_nxt = (pen_r & ~wmask[13:0])
                                            | (wdata_r[13:0] & wmask[13:0]);
                default: p = prio_r;
            endcase
            // a level 0 field keeps its old value
            for (int f = 0; f < 16; f++) begin
                if (p[2*f +: 2] == nic_pkg::LVL0) begin
                    p[2*f +: 2] = prio_r[2*f +: 2];
                end
            end
            prio_nxt = p | nic_pkg::PRIO_RO_ONES;
        end
        if (ARVALID && ARREADY) begin
            rvalid_nxt = 1'b1;
            rdata_nxt = rd_hit ? rd_val : 32'h00000000;
            rresp_nxt = rd_hit ? nic_pkg::RESP_OKAY : nic_pkg::RESP_SLVERR;
        end
    end

    // request lines of the sources
    always_comb begin
        for (int g = 0; g < nic_pkg::NGRP; g++) begin
            line[g] = |(EXT_PINS[g*GRP_W +: GRP_W] & pinen_r[g*GRP_W +: GRP_W]);
            ext_req[g] = (sens_r[2*g +: 2] == nic_pkg::SENS_LOW)
                         ? !line[g] : ext_lat_r[g];
        end
        for (int v = 0; v < nic_pkg::NVEC; v++) begin
            pend[v] = nic_pkg::PERIPH_VECS[v]
                      && per_lat_r[v] && PERIPH_FLAG[v] && pen_r[v];
        end
        pend[0] = tli_lat_r && sens_r[nic_pkg::TLI_EN_BIT] && !in_tli_r;
        for (int g = 0; g < nic_pkg::NGRP; g++) begin
            pend[nic_pkg::EXT_VEC0 + g] = ext_req[g];
        end
    end

    // arbitration: software rank first, lower vector wins ties
    always_comb begin
        logic [2:0] r;
        r = 3'd0;
        found = 1'b0;
        best_idx = 4'h0;
        best_rank = 3'd0;
        for (int v = nic_pkg::NVEC - 1; v >= 0; v--) begin
            r = (v == 0) ? 3'd4 : rank(prio_r[2*v +: 2]);
            if (pend[v] && r > rank(level_r) && (!found || r >= best_rank)) begin
                found = 1'b1;
                best_idx = 4'(v);
                best_rank = r;
            end
        end
    end

    assign take = (state_r == nic_pkg::NIC_RUN) && CPU_INSTR_END
                  && (trap_lat_r || found);

    // sequencing and source latches
    always_comb begin
        logic edg;
        logic [13:0] per_now;
        edg = 1'b0;
        per_now = PERIPH_FLAG & pen_r;
        state_nxt = state_r;
        sel_nxt = sel_r;
        sel_trap_nxt = sel_trap_r;
        sel_lvl_nxt = sel_lvl_r;
        level_nxt = level_r;
        vec_nxt = vec_r;
        in_tli_nxt = in_tli_r;
        ext_prev_nxt = line;
        tli_prev_nxt = TOP_LEVEL_PIN;
        per_prev_nxt = per_now;
        ext_lat_nxt = ext_lat_r;
        tli_lat_nxt = tli_lat_r;
        trap_lat_nxt = trap_lat_r;
        // clear sequence drops the latch before the new set
        per_lat_nxt = per_lat_r & ~pclr;
        if ((state_r == nic_pkg::NIC_RUN) && (CPU_CC_LOAD || RETURN_FROM_IRQ)) begin
            level_nxt = {CPU_CC_DATA[nic_pkg::CC_HI_BIT],
                         CPU_CC_DATA[nic_pkg::CC_LO_BIT]};
            if (RETURN_FROM_IRQ) begin
                in_tli_nxt = 1'b0;
            end
        end
        case (state_r)
            nic_pkg::NIC_RSTV: begin
                vec_nxt = nic_pkg::VEC_RESET;
                level_nxt = nic_pkg::LVL3;
                state_nxt = nic_pkg::NIC_VECT;
            end
            nic_pkg::NIC_RUN: begin
                if (take) begin
                    state_nxt = nic_pkg::NIC_STACK;
                    sel_trap_nxt = trap_lat_r;
                    sel_nxt = best_idx;
                    sel_lvl_nxt = (trap_lat_r || best_idx == 4'h0)
                                  ? nic_pkg::LVL3 : prio_r[2*best_idx +: 2];
                    if (trap_lat_r) begin
                        trap_lat_nxt = 1'b0;
                    end else if (best_idx == 4'h0) begin
                        tli_lat_nxt = 1'b0;
                        in_tli_nxt = 1'b1;
                    end else if (best_idx >= 4'(nic_pkg::EXT_VEC0)
                                 && best_idx < 4'(nic_pkg::EXT_VEC0 + nic_pkg::NGRP)) begin
                        ext_lat_nxt[2'(best_idx - 4'(nic_pkg::EXT_VEC0))] = 1'b0;
                    end
                end
            end
            nic_pkg::NIC_STACK: begin
                if (CPU_STACK_DONE) begin
                    level_nxt = sel_lvl_r;
                    vec_nxt = sel_trap_r ? nic_pkg::VEC_TRAP
                              : 16'(nic_pkg::VEC_TOP - {11'h000, sel_r, 1'b0});
                    state_nxt = nic_pkg::NIC_VECT;
                end
            end
            nic_pkg::NIC_VECT: state_nxt = nic_pkg::NIC_RUN;
            default: state_nxt = nic_pkg::NIC_RUN;
        endcase
        // new events set after any clear, so a same-cycle event survives
        for (int g = 0; g < nic_pkg::NGRP; g++) begin
            case (sens_r[2*g +: 2])
                nic_pkg::SENS_RISE: edg = line[g] && !ext_prev_r[g];
                nic_pkg::SENS_FALL: edg = !line[g] && ext_prev_r[g];
                nic_pkg::SENS_BOTH: edg = line[g] != ext_prev_r[g];
                default: edg = 1'b0;
            endcase
            if (edg) begin
                ext_lat_nxt[g] = 1'b1;
            end
        end
        edg = sens_r[nic_pkg::TLI_EDGE_BIT] ? (TOP_LEVEL_PIN && !tli_prev_r)
                                            : (!TOP_LEVEL_PIN && tli_prev_r);
        if (edg) begin
            tli_lat_nxt = 1'b1;
        end
        if (CPU_TRAP) begin
            trap_lat_nxt = 1'b1;
        end
        per_lat_nxt = per_lat_nxt | (per_now & ~per_prev_r);
    end

    always_ff @(posedge MCLK or negedge NRST) begin
        if (!NRST) begin
            prio_r <= nic_pkg::PRIO_RST;
            sens_r <= nic_pkg::SENS_RST;
            pinen_r <= '0;
            pen_r <= 14'h0000;
            aw_hold_r <= 1'b0;
            w_hold_r <= 1'b0;
            awaddr_r <= 8'h00;
            wdata_r <= 32'h00000000;
            wstrb_r <= 4'h0;
            bvalid_r <= 1'b0;
            bresp_r <= nic_pkg::RESP_OKAY;
            rvalid_r <= 1'b0;
            rresp_r <= nic_pkg::RESP_OKAY;
            rdata_r <= 32'h00000000;
            ext_prev_r <= '0;
            ext_lat_r <= '0;
            per_prev_r <= 14'h0000;
            per_lat_r <= 14'h0000;
            tli_prev_r <= 1'b0;
            tli_lat_r <= 1'b0;
            trap_lat_r <= 1'b0;
            in_tli_r <= 1'b0;
            state_r <= nic_pkg::NIC_RSTV;
            sel_r <= 4'h0;
            sel_trap_r <= 1'b0;
            sel_lvl_r <= nic_pkg::LVL3;
            level_r <= nic_pkg::LVL3;
            vec_r <= nic_pkg::VEC_RESET;
        end else begin
            prio_r <= prio_nxt;
            sens_r <= sens_nxt;
            pinen_r <= pinen_nxt;
            pen_r <= pen_nxt;
            aw_hold_r <= aw_hold_nxt;
            w_hold_r <= w_hold_nxt;
            awaddr_r <= awaddr_nxt;
            wdata_r <= wdata_nxt;
            wstrb_r <= wstrb_nxt;
            bvalid_r <= bvalid_nxt;
            bresp_r <= bresp_nxt;
            rvalid_r <= rvalid_nxt;
            rresp_r <= rresp_nxt;
            rdata_r <= rdata_nxt;
            ext_prev_r <= ext_prev_nxt;
            ext_lat_r <= ext_lat_nxt;
            per_prev_r <= per_prev_nxt;
            per_lat_r <= per_lat_nxt;
            tli_prev_r <= tli_prev_nxt;
            tli_lat_r <= tli_lat_nxt;
            trap_lat_r <= trap_lat_nxt;
            in_tli_r <= in_tli_nxt;
            state_r <= state_nxt;
            sel_r <= sel_nxt;
            sel_trap_r <= sel_trap_nxt;
            sel_lvl_r <= sel_lvl_nxt;
            level_r <= level_nxt;
            vec_r <= vec_nxt;
        end
    end

    // outputs
    assign AWREADY = !aw_hold_r && !bvalid_r;
    assign WREADY = !w_hold_r && !bvalid_r;
    assign BVALID = bvalid_r;
    assign BRESP = bresp_r;
    assign ARREADY = !rvalid_r;
    assign RVALID = rvalid_r;
    assign RDATA = rdata_r;
    assign RRESP = rresp_r;
    assign CPU_STACK_REQ = (state_r == nic_pkg::NIC_STACK);
    assign CPU_VEC_LOAD = (state_r == nic_pkg::NIC_VECT);
    assign PROGRAM_COUNTER_VEC = vec_r;
    // level bits sit at 5 and 3, others zero
    assign CONDITION_CODE_LVL = {2'b00, level_r[1], 1'b0, level_r[0], 3'b000};
    assign WAKE_WAIT = trap_lat_r || (|pend);
    assign WAKE_STOP = trap_lat_r || pend[0] || (|ext_req);

    chk_reset_vec: assert property (@(posedge MCLK) disable iff (!NRST)
        state_r == nic_pkg::NIC_RSTV |=> CPU_VEC_LOAD
            && PROGRAM_COUNTER_VEC == nic_pkg::VEC_RESET && level_r == nic_pkg::LVL3)
        else $error("reset vector not loaded at level 3");
    chk_nmi_level: assert property (@(posedge MCLK) disable iff (!NRST)
        CPU_VEC_LOAD && PROGRAM_COUNTER_VEC >= nic_pkg::VEC_TOP
            |-> level_r == nic_pkg::LVL3)
        else $error("top vectors not entered at level 3");
    chk_stack_first: assert property (@(posedge MCLK) disable iff (!NRST)
        CPU_VEC_LOAD && PROGRAM_COUNTER_VEC != nic_pkg::VEC_RESET
            |-> $past(state_r) == nic_pkg::NIC_STACK && $past(CPU_STACK_DONE))
        else $error("vector loaded without stacking");
    chk_instr_end: assert property (@(posedge MCLK) disable iff (!NRST)
        state_r == nic_pkg::NIC_RUN ##1 state_r == nic_pkg::NIC_STACK
            |-> $past(CPU_INSTR_END))
        else $error("entry taken mid instruction");
    chk_no_lvl0: assert property (@(posedge MCLK) disable iff (!NRST)
        wr_go |=> prio_r[1:0] != nic_pkg::LVL0 && prio_r[9:8] != nic_pkg::LVL0
            && prio_r[27:26] != nic_pkg::LVL0)
        else $error("level 0 stored in priority field");
    chk_vec_addr: assert property (@(posedge MCLK) disable iff (!NRST)
        CPU_VEC_LOAD && !sel_trap_r && $past(state_r) == nic_pkg::NIC_STACK
            |-> PROGRAM_COUNTER_VEC == 16'(nic_pkg::VEC_TOP - {11'h000, sel_r, 1'b0}))
        else $error("wrong vector address");
    chk_mask_rank: assert property (@(posedge MCLK) disable iff (!NRST)
        take && !trap_lat_r && best_idx != 4'h0
            |-> rank(prio_r[2*best_idx +: 2]) > rank(level_r) ##2 1'b1)
        else $error("masked request taken");
    chk_return_from_irq_lvl: assert property (@(posedge MCLK) disable iff (!NRST)
        state_r == nic_pkg::NIC_RUN && RETURN_FROM_IRQ
            |=> CONDITION_CODE_LVL[5] == $past(CPU_CC_DATA[5])
            && CONDITION_CODE_LVL[3] == $past(CPU_CC_DATA[3]))
        else $error("level not restored on return");
    chk_trap_wake: assert property (@(posedge MCLK) disable iff (!NRST)
        $rose(trap_lat_r) |-> WAKE_STOP && WAKE_WAIT)
        else $error("trap does not wake");
endmodule // nic_top

// ---- verif/nic_cpu_model.sv ----
// nic_cpu_model: core stand-in, ends instructions and answers stacking
// assumes: stall set by the bench, stack done comes stall+1 cycles later
`timescale 1ns/1ps
module nic_cpu_model (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic stack_req,
    input wire logic [3:0] stall,
    output logic instr_end,
    output logic stack_done
);
    logic [3:0] sc_r;
    logic [1:0] ic_r;
    // instruction ends every fourth cycle, none while stacking
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            sc_r <= 4'h0;
            ic_r <= 2'h0;
            instr_end <= 1'h0;
            stack_done <= 1'h0;
        end else begin
            ic_r <= ic_r + 2'h1;
            instr_end <= !stack_req && (ic_r == 2'h3);
            sc_r <= (stack_req && !stack_done) ? sc_r + 4'h1 : 4'h0;
            stack_done <= stack_req && !stack_done && (sc_r == stall);
        end
    end
endmodule // nic_cpu_model

// ---- verif/nic_top_bench.sv ----
// nic_top_bench: register and interrupt entry tests of nic_top
// assumes: nic_cpu_model drives the core handshake
`timescale 1ns/1ps
module nic_top_bench;
    logic mclk, nrst, awvalid, wvalid, bready, arvalid, rready;
    logic tpin, trap, ret, ccld, awready, wready, bvalid, arready, rvalid;
    logic ie, sd, sreq, vld, wkw, wks;
    logic [7:0] awaddr, araddr, ccd, cclvl;
    logic [31:0] wdata, rdata;
    logic [1:0] bresp, rresp;
    logic [15:0] ext, pcv;
    logic [13:0] pfl;
    logic [3:0] stall;
    int n_errors = 0;
    int check_count = 0;
    int cyc = 0;
    nic_top i_dut (.MCLK(mclk), .NRST(nrst), .AWADDR(awaddr),
        .AWVALID(awvalid), .AWREADY(awready), .WDATA(wdata), .WSTRB(4'hF),
        .WVALID(wvalid), .WREADY(wready), .BRESP(bresp), .BVALID(bvalid),
        .BREADY(bready), .ARADDR(araddr), .ARVALID(arvalid),
        .ARREADY(arready), .RDATA(rdata), .RRESP(rresp), .RVALID(rvalid),
        .RREADY(rready), .TOP_LEVEL_PIN(tpin), .EXT_PINS(ext),
        .PERIPH_FLAG(pfl), .CPU_INSTR_END(ie), .CPU_TRAP(trap),
        .CPU_STACK_DONE(sd), .RETURN_FROM_IRQ(ret), .CPU_CC_LOAD(ccld),
        .CPU_CC_DATA(ccd), .CPU_STACK_REQ(sreq), .CPU_VEC_LOAD(vld),
        .PROGRAM_COUNTER_VEC(pcv), .CONDITION_CODE_LVL(cclvl),
        .WAKE_WAIT(wkw), .WAKE_STOP(wks));
    nic_cpu_model i_cpu (.clk(mclk), .rst_n(nrst), .stack_req(sreq),
        .stall(stall), .instr_end(ie), .stack_done(sd));
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            n_errors++;
            $display("BAD %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d,
                      input logic [1:0] er);
        logic ah, wh, bh;
        @(posedge mclk);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'h1;
        wvalid <= 1'h1;
        bready <= 1'h1;
        bh = 1'h0;
        while (!bh) begin
            @(negedge mclk);
            ah = awvalid && awready;
            wh = wvalid && wready;
            bh = bvalid;
            if (bh) chk({30'h0, bresp}, {30'h0, er});
            @(posedge mclk);
            if (ah) awvalid <= 1'h0;
            if (wh) wvalid <= 1'h0;
            if (bh) bready <= 1'h0;
        end
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] ed,
                      input logic [1:0] er);
        logic ah, rh;
        @(posedge mclk);
        araddr <= a;
        arvalid <= 1'h1;
        rready <= 1'h1;
        rh = 1'h0;
        while (!rh) begin
            @(negedge mclk);
            ah = arvalid && arready;
            rh = rvalid;
            if (rh) chk(rdata, ed);
            if (rh) chk({30'h0, rresp}, {30'h0, er});
            @(posedge mclk);
            if (ah) arvalid <= 1'h0;
            if (rh) rready <= 1'h0;
        end
    endtask
    // one-cycle return or software level load with a condition code
    task automatic core(input logic [7:0] c, input logic r);
        @(posedge mclk);
        ccd <= c;
        if (r) ret <= 1'h1;
        else ccld <= 1'h1;
        @(posedge mclk);
        ret <= 1'h0;
        ccld <= 1'h0;
    endtask
    task automatic wvec(input logic [15:0] pc, input logic [7:0] cc);
        int t;
        int ns;
        t = 0;
        ns = 0;
        do begin
            @(negedge mclk);
            t++;
            if (sreq === 1'h1) ns++;
        end while (vld !== 1'h1 && t < 200);
        chk({15'h0, vld, pcv}, {15'h0, 1'h1, pc});
        chk({24'h0, cclvl}, {24'h0, cc});
        // stacking lasts the model's stall plus two, none for reset
        chk(ns, (pc == 16'hFFFE) ? 32'h0 : 32'(stall) + 32'h2);
    endtask
    task give_verdict;
        $display("errors %0d checks %0d", n_errors, check_count);
        if (n_errors == 0 && check_count > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask
    // clock and hang guard
    initial begin
        mclk = 1'h0;
        forever #25 mclk = ~mclk;
    end
    always @(posedge mclk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            n_errors++;
            give_verdict;
        end
    end
    // main sequence
    initial begin
        nrst = 1'h0;
        {awvalid, wvalid, bready, arvalid, rready} = 5'h0;
        {tpin, trap, ret, ccld} = 4'h0;
        awaddr = 8'h0;
        araddr = 8'h0;
        wdata = 32'h0;
        ccd = 8'h0;
        ext = 16'h0;
        pfl = 14'h0;
        stall = 4'h0;
        repeat (4) @(posedge mclk);
        chk({24'h0, cclvl}, 32'h28);
        nrst <= 1'h1;
        wvec(16'hFFFE, 8'h28);
        rd(nic_pkg::OFS_PRIO3, 32'hFF, nic_pkg::RESP_OKAY);
        rd(8'h40, 32'h0, nic_pkg::RESP_SLVERR);
        wr(8'h40, 32'h0, nic_pkg::RESP_SLVERR);
        wr(nic_pkg::OFS_PRIO0, 32'hCF, nic_pkg::RESP_OKAY);
        wr(nic_pkg::OFS_PRIO0, 32'h64, nic_pkg::RESP_OKAY);
        rd(nic_pkg::OFS_PRIO0, 32'h44, nic_pkg::RESP_OKAY);
        wr(nic_pkg::OFS_PEN, 32'h2, nic_pkg::RESP_OKAY);
        pfl[1] <= 1'h1;
        repeat (3) @(negedge mclk);
        chk({31'h0, wkw}, 32'h1);
        wr(nic_pkg::OFS_PCLR, 32'h2, nic_pkg::RESP_OKAY);
        @(negedge mclk);
        chk({31'h0, wkw}, 32'h0);
        @(posedge mclk);
        pfl <= 14'h0;
        trap <= 1'h1;
        @(posedge mclk);
        trap <= 1'h0;
        wvec(nic_pkg::VEC_TRAP, 8'h28);
        core(8'h28, 1'h1);
        core(8'h20, 1'h0);
        stall <= 4'h5;
        pfl[1] <= 1'h1;
        wvec(16'hFFF8, 8'h08);
        wr(nic_pkg::OFS_PCLR, 32'h2, nic_pkg::RESP_OKAY);
        core(8'h20, 1'h1);
        @(negedge mclk);
        chk({24'h0, cclvl}, 32'h20);
        wr(nic_pkg::OFS_SENS, 32'h300, nic_pkg::RESP_OKAY);
        wr(nic_pkg::OFS_PINEN, 32'h2, nic_pkg::RESP_OKAY);
        ext[1] <= 1'h1;
        wvec(16'hFFF6, 8'h00);
        chk({31'h0, wks}, 32'h0);
        @(posedge mclk);
        tpin <= 1'h1;
        wvec(nic_pkg::VEC_TOP, 8'h28);
        give_verdict;
    end
endmodule // nic_top_bench
